// File: src/bsf_unit.sv
// Bit, shift and flag execution unit with an APB register port.
// Assumes an APB master on pclk; operands and ops arrive by register.
//
// Behaviour
// - I/O bit set or clear forces one I/O register bit in two cycles.
// - Left shift moves bits up, 0 into bit 0, one cycle, sets Z C N V.
// - Right shift moves bits down, 0 into bit 7, sets Z C N V.
// - Rotate left puts old carry in bit 0 and old bit 7 into carry.
// - Rotate right puts old carry in bit 7 and old bit 0 into carry.
// - Arithmetic right shift moves bits down and keeps the sign bit.
// - Nibble swap exchanges the two halves and touches no flag.
// - Flag set or clear writes 1 or 0 into the one selected flag bit.
// - Bit store copies the selected source bit into the transfer flag.
// - Bit load copies the transfer flag into the selected dest bit.
// - Carry set and clear force carry in one cycle, no other flag moves.
// - Negative set and clear force the negative flag only.
// - Zero set and clear force the zero flag only.
//
// Chosen here: the address map and the APB slave port.
module bsf_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status
  output logic busy
);
  import bsf_pkg::*;

  bsf_regs_s q_ff;
  bsf_regs_s nxt_q;

  logic setup;
  logic wr_take;
  logic launch;
  logic addr_hit;
  logic [31:0] rd_word;
  bsf_op_e w_op;
  logic [BIT_W-1:0] w_bit;
  logic [IO_W-1:0] w_io;
  logic [7:0] io_new;
  logic [7:0] flag_new;
  logic [7:0] bld_new;
  logic [7:0] sh_res;
  logic sh_c;
  logic sh_valid;
  logic [3:0][7:0] io_view;
  logic wr_io_hit;
  logic [IO_W-1:0] wr_io_idx;

  // Fields of a write to the operation control register
  assign w_op = bsf_op_e'(pwdata[OP_LSB +: OP_W]);
  assign w_bit = pwdata[BIT_LSB +: BIT_W];
  assign w_io = pwdata[IO_LSB +: IO_W];

  assign setup = psel & ~penable;
  assign wr_take = psel & penable & q_ff.pready & pwrite;
  // A new op is refused while an I/O op is still in flight
  assign launch = wr_take & (paddr == OFS_OPCTL) & (q_ff.state == ST_IDLE);

  // Selected I/O bit forced to 1 or 0
  bsf_bit_put #(
    .WIDTH(8),
    .IDXW(BIT_W)
  ) u_io_put (
    .word_in(q_ff.io[q_ff.io_idx]),
    .bit_idx(q_ff.bit_idx),
    .bit_val(q_ff.op == OP_IO_SET),
    .word_out(io_new)
  );

  // Selected flag forced to 1 or 0
  bsf_bit_put #(
    .WIDTH(8),
    .IDXW(BIT_W)
  ) u_flag_put (
    .word_in(q_ff.flags),
    .bit_idx(w_bit),
    .bit_val(w_op == OP_FLAG_ONE),
    .word_out(flag_new)
  );

  // Transfer flag placed into the destination
  bsf_bit_put #(
    .WIDTH(8),
    .IDXW(BIT_W)
  ) u_bld_put (
    .word_in(q_ff.dest),
    .bit_idx(w_bit),
    .bit_val(q_ff.flags[FLG_T]),
    .word_out(bld_new)
  );

  // Shift and rotate results with their carry out
  always_comb begin
    sh_res = q_ff.dest;
    sh_c = q_ff.flags[FLG_C];
    sh_valid = 1'b1;
    case (w_op)
      OP_LSL: begin
        sh_res = {q_ff.dest[6:0], 1'b0};
        sh_c = q_ff.dest[7];
      end
      OP_LSR: begin
        sh_res = {1'b0, q_ff.dest[7:1]};
        sh_c = q_ff.dest[0];
      end
      OP_ROL: begin
        sh_res = {q_ff.dest[6:0], q_ff.flags[FLG_C]};
        sh_c = q_ff.dest[7];
      end
      OP_ROR: begin
        sh_res = {q_ff.flags[FLG_C], q_ff.dest[7:1]};
        sh_c = q_ff.dest[0];
      end
      OP_ASR: begin
        sh_res = {q_ff.dest[7], q_ff.dest[7:1]};
        sh_c = q_ff.dest[0];
      end
      default: begin
        sh_valid = 1'b0;
      end
    endcase
  end

  // In-flight I/O result shown to a read that sets up in the same cycle
  always_comb begin
    io_view = q_ff.io;
    if (q_ff.state == ST_IO) begin
      io_view[q_ff.io_idx] = io_new;
    end
  end

  // Which I/O register a plain write targets
  always_comb begin
    wr_io_hit = 1'b1;
    wr_io_idx = 2'h0;
    case (paddr)
      OFS_IO0: begin
        wr_io_idx = 2'h0;
      end
      OFS_IO1: begin
        wr_io_idx = 2'h1;
      end
      OFS_IO2: begin
        wr_io_idx = 2'h2;
      end
      OFS_IO3: begin
        wr_io_idx = 2'h3;
      end
      default: begin
        wr_io_hit = 1'b0;
      end
    endcase
  end

  // Register read mux; unmapped addresses answer with an error
  always_comb begin
    rd_word = RST_WORD;
    addr_hit = 1'b1;
    case (paddr)
      OFS_OPCTL: begin
        rd_word[OP_LSB +: OP_W] = q_ff.op;
        rd_word[BIT_LSB +: BIT_W] = q_ff.bit_idx;
        rd_word[IO_LSB +: IO_W] = q_ff.io_idx;
      end
      OFS_DEST: begin
        rd_word[7:0] = q_ff.dest;
      end
      OFS_SRC: begin
        rd_word[7:0] = q_ff.src;
      end
      OFS_FLAGS: begin
        rd_word[7:0] = q_ff.flags;
      end
      OFS_STATUS: begin
        rd_word[ST_BUSY_BIT] = (q_ff.state == ST_IO);
        rd_word[ST_BADOP_BIT] = q_ff.bad_op;
        rd_word[ST_CNT_LSB +: 8] = q_ff.op_cnt;
      end
      OFS_IO0: begin
        rd_word[7:0] = io_view[0];
      end
      OFS_IO1: begin
        rd_word[7:0] = io_view[1];
      end
      OFS_IO2: begin
        rd_word[7:0] = io_view[2];
      end
      OFS_IO3: begin
        rd_word[7:0] = io_view[3];
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Next state of the whole unit
  always_comb begin
    nxt_q = q_ff;
    nxt_q.pready = 1'b0;
    nxt_q.pslverr = 1'b0;

    // Fixed one-cycle access phase keeps the master's wait short
    if (setup) begin
      nxt_q.pready = 1'b1;
      nxt_q.pslverr = ~addr_hit;
      if (!pwrite) begin
        nxt_q.prdata = rd_word;
      end
    end

    // Plain register writes
    if (wr_take) begin
      case (paddr)
        OFS_DEST: begin
          nxt_q.dest = pwdata[7:0];
        end
        OFS_SRC: begin
          nxt_q.src = pwdata[7:0];
        end
        OFS_FLAGS: begin
          nxt_q.flags = pwdata[7:0];
        end
        OFS_STATUS: begin
          if (pwdata[ST_BADOP_BIT]) begin
            nxt_q.bad_op = 1'b0;
          end
        end
        OFS_IO0: begin
          nxt_q.io[0] = pwdata[7:0];
        end
        OFS_IO1: begin
          nxt_q.io[1] = pwdata[7:0];
        end
        OFS_IO2: begin
          nxt_q.io[2] = pwdata[7:0];
        end
        OFS_IO3: begin
          nxt_q.io[3] = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // Sequencer; only I/O ops need a second cycle
    case (q_ff.state)
      ST_IDLE: begin
        if (launch) begin
          nxt_q.op = w_op;
          nxt_q.bit_idx = w_bit;
          nxt_q.io_idx = w_io;
          nxt_q.op_cnt = q_ff.op_cnt + 8'h01;
          case (w_op)
            OP_IO_SET, OP_IO_CLR: begin
              nxt_q.state = ST_IO;
            end
            OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
              if (sh_valid) begin
                nxt_q.dest = sh_res;
                nxt_q.flags[FLG_C] = sh_c;
                nxt_q.flags[FLG_Z] = (sh_res == RST_BYTE);
                nxt_q.flags[FLG_N] = sh_res[7];
                nxt_q.flags[FLG_V] = sh_res[7] ^ sh_c;
              end
            end
            OP_SWAP: begin
              nxt_q.dest = {q_ff.dest[3:0], q_ff.dest[7:4]};
            end
            OP_FLAG_ONE, OP_FLAG_ZERO: begin
              nxt_q.flags = flag_new;
            end
            OP_BIT_TO_T: begin
              nxt_q.flags[FLG_T] = q_ff.src[w_bit];
            end
            OP_T_TO_BIT: begin
              nxt_q.dest = bld_new;
            end
            OP_C_ONE: begin
              nxt_q.flags[FLG_C] = 1'b1;
            end
            OP_C_ZERO: begin
              nxt_q.flags[FLG_C] = 1'b0;
            end
            OP_N_ONE: begin
              nxt_q.flags[FLG_N] = 1'b1;
            end
            OP_N_ZERO: begin
              nxt_q.flags[FLG_N] = 1'b0;
            end
            OP_Z_ONE: begin
              nxt_q.flags[FLG_Z] = 1'b1;
            end
            OP_Z_ZERO: begin
              nxt_q.flags[FLG_Z] = 1'b0;
            end
            OP_NOP: begin
            end
            default: begin
              // Unknown code; set beats a same-cycle clear
              nxt_q.bad_op = 1'b1;
            end
          endcase
        end
      end
      ST_IO: begin
        // A plain write to the same register in this cycle is newer
        if (!(wr_take && wr_io_hit && (wr_io_idx == q_ff.io_idx))) begin
          nxt_q.io[q_ff.io_idx] = io_new;
        end
        nxt_q.state = ST_IDLE;
      end
      default: begin
        nxt_q.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff.pready <= 1'b0;
      q_ff.pslverr <= 1'b0;
      q_ff.prdata <= RST_WORD;
      q_ff.state <= ST_IDLE;
      q_ff.op <= OP_NOP;
      q_ff.bit_idx <= '0;
      q_ff.io_idx <= '0;
      q_ff.dest <= RST_BYTE;
      q_ff.src <= RST_BYTE;
      q_ff.flags <= RST_BYTE;
      q_ff.io <= '0;
      q_ff.bad_op <= 1'b0;
      q_ff.op_cnt <= RST_BYTE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata = q_ff.prdata;
  assign pready = q_ff.pready;
  assign pslverr = q_ff.pslverr;
  assign busy = q_ff.state[1];

endmodule

// File: src/bsf_pkg.sv
// Constants, op codes and state types of the bit, shift and flag unit.
// Assumes a 32-bit APB master on pclk and an 8-bit data path.
package bsf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_OPCTL = 8'h00;
  localparam logic [7:0] OFS_DEST = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IO0 = 8'h14;
  localparam logic [7:0] OFS_IO1 = 8'h18;
  localparam logic [7:0] OFS_IO2 = 8'h1C;
  localparam logic [7:0] OFS_IO3 = 8'h20;

  // Operation control fields
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int BIT_LSB = 8;
  localparam int BIT_W = 3;
  localparam int IO_LSB = 12;
  localparam int IO_W = 2;

  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_BADOP_BIT = 1;
  localparam int ST_CNT_LSB = 8;

  // Flag word bit positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_T = 3'h6;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Operation codes
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_IO_SET = 5'h01,
    OP_IO_CLR = 5'h02,
    OP_LSL = 5'h03,
    OP_LSR = 5'h04,
    OP_ROL = 5'h05,
    OP_ROR = 5'h06,
    OP_ASR = 5'h07,
    OP_SWAP = 5'h08,
    OP_FLAG_ONE = 5'h09,
    OP_FLAG_ZERO = 5'h0A,
    OP_BIT_TO_T = 5'h0B,
    OP_T_TO_BIT = 5'h0C,
    OP_C_ONE = 5'h0D,
    OP_C_ZERO = 5'h0E,
    OP_N_ONE = 5'h0F,
    OP_N_ZERO = 5'h10,
    OP_Z_ONE = 5'h11,
    OP_Z_ZERO = 5'h12
  } bsf_op_e;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_IO = 2'b10
  } bsf_state_e;

  // Whole state of the unit
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    bsf_state_e state;
    bsf_op_e op;
    logic [BIT_W-1:0] bit_idx;
    logic [IO_W-1:0] io_idx;
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] flags;
    logic [3:0][7:0] io;
    logic bad_op;
    logic [7:0] op_cnt;
  } bsf_regs_s;

endpackage

// File: src/bsf_bit_put.sv
// Writes one selected bit of a word, leaving every other bit alone.
// Assumes an in-range index; combinational only.
module bsf_bit_put #(
  parameter int WIDTH = 8,
  parameter int IDXW = 3
) (
  // Operand
  input wire logic [WIDTH-1:0] word_in,
  input wire logic [IDXW-1:0] bit_idx,
  input wire logic bit_val,
  // Result
  output logic [WIDTH-1:0] word_out
);

  always_comb begin
    word_out = word_in;
    word_out[bit_idx] = bit_val;
  end

endmodule

// File: test/bsf_unit_sva.sv
// Port checker for the bit, shift and flag unit.
// Bound to bsf_unit; one clock domain, ports only.
module bsf_unit_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  import bsf_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire op_wr = acc && pwrite && paddr == OFS_OPCTL && !busy;
  wire io_op = pwdata[4:0] inside {OP_IO_SET, OP_IO_CLR};
  sequence s_io_go;
    op_wr && io_op;
  endsequence
  sequence s_busy_one;
    busy ##1 !busy;
  endsequence
  io_busy_a: assert property (s_io_go |=> s_busy_one)
    else $error("io op busy length");
  busy_cause_a: assert property (
    $rose(busy) |-> $past(op_wr && io_op))
    else $error("busy without io op");
  fast_op_a: assert property (op_wr && !io_op |=> !busy)
    else $error("one cycle op went busy");
  ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready pulse");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (
    psel && !penable && paddr > OFS_IO3 |=> pslverr)
    else $error("unmapped not refused");
  unmapped_zero_a: assert property (
    acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read data");
  rdata_hold_a: assert property (
    $changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved");
endmodule

bind bsf_unit bsf_unit_sva u_bsf_unit_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));

// File: test/bsf_issuer.sv
// APB issuer standing in for the decoder and register file.
// Drives just after rising pclk; waits for pready, the bench watchdog ends a hang.
module bsf_issuer (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rd_data;
  logic rd_err;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Op, bit and register index go together in one word
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= '1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= '0;
    penable <= '0;
    // Idle edge keeps two drives of psel out of one step
    @(posedge pclk);
  endtask
endmodule

// File: test/bsf_unit_bench.sv
// Self-checking bench for the bit, shift and flag unit.
// Assumes bsf_issuer as APB master and the checker bound in.
module bsf_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bsf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int failures, cmp_count, busy_cnt;
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  bsf_issuer u_bsf_issuer (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bsf_unit u_bsf_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  always @(posedge pclk) if (busy === 1'b1) busy_cnt++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_bsf_issuer.xfer('1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_bsf_issuer.xfer('0, a, '0);
    chk(u_bsf_issuer.rd_data, exp);
  endtask
  function automatic logic [15:0] ref_op(input logic [4:0] op,
    input logic [2:0] b, input logic [7:0] d, s, fi);
    logic [7:0] r;
    logic [7:0] f;
    logic c;
    r = d;
    f = fi;
    c = f[FLG_C];
    case (op)
      OP_LSL: {c, r} = {d, 1'b0};
      OP_LSR: {r, c} = {1'b0, d};
      OP_ROL: {c, r} = {d, f[FLG_C]};
      OP_ROR: {r, c} = {f[FLG_C], d};
      OP_ASR: {r, c} = {d[7], d};
      OP_SWAP: r = {d[3:0], d[7:4]};
      OP_FLAG_ONE: f[b] = 1'b1;
      OP_FLAG_ZERO: f[b] = 1'b0;
      OP_BIT_TO_T: f[FLG_T] = s[b];
      OP_T_TO_BIT: r[b] = f[FLG_T];
      OP_C_ONE: f[FLG_C] = 1'b1;
      OP_C_ZERO: f[FLG_C] = 1'b0;
      OP_N_ONE: f[FLG_N] = 1'b1;
      OP_N_ZERO: f[FLG_N] = 1'b0;
      OP_Z_ONE: f[FLG_Z] = 1'b1;
      OP_Z_ZERO: f[FLG_Z] = 1'b0;
      default: r = d;
    endcase
    if (op inside {[OP_LSL:OP_ASR]}) begin
      f[FLG_C] = c;
      f[FLG_Z] = (r == 8'h00);
      f[FLG_N] = r[7];
      f[FLG_V] = r[7] ^ c;
    end
    return {r, f};
  endfunction
  task automatic run_op(input logic [4:0] op, input logic [2:0] b,
    input logic [7:0] d, s, f);
    logic [15:0] e;
    e = ref_op(op, b, d, s, f);
    wr(OFS_DEST, 32'(d));
    wr(OFS_SRC, 32'(s));
    wr(OFS_FLAGS, 32'(f));
    wr(OFS_OPCTL, 32'({b, 3'h0, op}));
    rdc(OFS_DEST, 32'(e[15:8]));
    rdc(OFS_FLAGS, 32'(e[7:0]));
    rdc(OFS_SRC, 32'(s));
  endtask
  task automatic t_reset();
    rdc(OFS_DEST, RST_WORD);
    rdc(OFS_FLAGS, RST_WORD);
    rdc(OFS_STATUS, RST_WORD);
  endtask
  task automatic t_err();
    u_bsf_issuer.xfer('0, 8'h40, '0);
    chk(u_bsf_issuer.rd_data, 32'h0000_0000);
    chk(32'(u_bsf_issuer.rd_err), 32'h0000_0001);
    wr(OFS_OPCTL, 32'h0000_001F);
    rdc(OFS_DEST, RST_WORD);
    u_bsf_issuer.xfer('0, OFS_STATUS, '0);
    chk(u_bsf_issuer.rd_data & 32'h0000_0003, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0002);
    u_bsf_issuer.xfer('0, OFS_STATUS, '0);
    chk(u_bsf_issuer.rd_data & 32'h0000_0003, 32'h0000_0000);
  endtask
  task automatic t_io();
    int n0;
    n0 = busy_cnt;
    wr(OFS_IO2, 32'h0000_005A);
    wr(OFS_OPCTL, 32'h0000_2001);
    rdc(OFS_IO2, 32'h0000_005B);
    wr(OFS_OPCTL, 32'h0000_2602);
    rdc(OFS_IO2, 32'h0000_001B);
    rdc(OFS_IO1, 32'h0000_0000);
    chk(32'(busy_cnt - n0), 32'h0000_0002);
  endtask
  task automatic t_shift();
    run_op(OP_LSL, 3'h0, 8'h81, 8'h00, 8'hF1);
    run_op(OP_LSL, 3'h0, 8'h80, 8'h00, 8'h00);
    run_op(OP_LSR, 3'h0, 8'h81, 8'h00, 8'hF1);
    run_op(OP_ROL, 3'h0, 8'h81, 8'h00, 8'hF1);
    run_op(OP_ROR, 3'h0, 8'h01, 8'h00, 8'h00);
    run_op(OP_ROR, 3'h0, 8'h81, 8'h00, 8'hF1);
    run_op(OP_ASR, 3'h0, 8'hA5, 8'h00, 8'h00);
    run_op(OP_SWAP, 3'h0, 8'h3C, 8'h00, 8'hAF);
    run_op(OP_NOP, 3'h0, 8'h5A, 8'h00, 8'h3C);
  endtask
  task automatic t_flag();
    for (int b = 0; b < 8; b++) begin
      run_op(OP_FLAG_ONE, 3'(b), 8'h00, 8'h00, 8'h00);
      run_op(OP_FLAG_ZERO, 3'(b), 8'h00, 8'h00, 8'hFF);
    end
    run_op(OP_BIT_TO_T, 3'h5, 8'h00, 8'h20, 8'h00);
    run_op(OP_BIT_TO_T, 3'h4, 8'h00, 8'hEF, 8'hFF);
    run_op(OP_T_TO_BIT, 3'h3, 8'h00, 8'h00, 8'h40);
    run_op(OP_C_ONE, 3'h0, 8'h00, 8'h00, 8'h00);
    run_op(OP_C_ZERO, 3'h0, 8'h00, 8'h00, 8'hFF);
    run_op(OP_N_ONE, 3'h0, 8'h00, 8'h00, 8'h00);
    run_op(OP_N_ZERO, 3'h0, 8'h00, 8'h00, 8'hFF);
    run_op(OP_Z_ONE, 3'h0, 8'h00, 8'h00, 8'h00);
    run_op(OP_Z_ZERO, 3'h0, 8'h00, 8'h00, 8'hFF);
  endtask
  task automatic t_rst_mid();
    wr(OFS_DEST, 32'h0000_00A5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatched %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100_000;
    failures++;
    wrap_up();
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    busy_cnt = 0;
    presetn = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_err();
    t_io();
    t_shift();
    t_flag();
    t_rst_mid();
    wrap_up();
  end
endmodule
